//--- chan_regs_pkg.sv
package chan_regs_pkg;
    localparam int NUM_CHANNELS = 4;
    localparam int CHAN_W = 2;
    localparam int CMD_W = 8;
    localparam int DATA_W = 8;
    localparam int SAMPLE_W = 16;
    localparam int CMD_RW_BIT = 7;
    localparam logic [6:0] CMD_CODE_RX_SLOT = 7'h05;
    localparam logic [6:0] CMD_CODE_MON_LOW = 7'h06;
    localparam logic [6:0] CMD_CODE_MON_HIGH = 7'h07;
    localparam logic [6:0] CMD_CODE_POWER = 7'h08;
    localparam logic [6:0] CMD_CODE_TONE = 7'h09;
    localparam int SLOT_W = 7;
    localparam int RX_HWY_BIT = 7;
    localparam logic [SLOT_W-1:0] RX_SLOT_RESET = 7'h00;
    localparam logic RX_HWY_RESET = 1'b0;
    localparam int SLEEP_BIT = 7;
    localparam int CUTOFF_BIT = 6;
    localparam int ADC_GAIN_BIT = 5;
    localparam int DAC_GAIN_BIT = 4;
    localparam logic SLEEP_RESET = 1'b1;
    localparam logic CUTOFF_RESET = 1'b0;
    localparam logic ADC_GAIN_RESET = 1'b0;
    localparam logic DAC_GAIN_RESET = 1'b0;
    localparam int TONE1_BIT = 1;
    localparam int TONE0_BIT = 0;
    localparam logic TONE_RESET = 1'b0;
    localparam logic [3:0] TONE_FIXED_BITS = 4'h3;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
endpackage

//--- chan_regs_if.sv
`timescale 1ns/1ps
interface chan_regs_if;
    import chan_regs_pkg::*;
    logic wr_en;
    logic [DATA_W-1:0] wr_data;
    logic [6:0] code;
    logic [SLOT_W-1:0] rx_slot_number;
    logic rx_highway_select;
    logic channel_sleep;
    logic rx_path_cutoff;
    logic adc_gain_boost;
    logic dac_gain_cut;
    logic tone_gen_zero_on;
    logic tone_gen_one_on;
    modport owner (
        input wr_en, wr_data, code,
        output rx_slot_number, rx_highway_select, channel_sleep, rx_path_cutoff,
        adc_gain_boost, dac_gain_cut, tone_gen_zero_on, tone_gen_one_on
    );
    modport user (
        output wr_en, wr_data, code,
        input rx_slot_number, rx_highway_select, channel_sleep, rx_path_cutoff,
        adc_gain_boost, dac_gain_cut, tone_gen_zero_on, tone_gen_one_on
    );
endinterface

//--- chan_reg_set.sv
`timescale 1ns/1ps
module chan_reg_set (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Register access
    chan_regs_if.owner bus
);
    import chan_regs_pkg::*;

    typedef struct packed {
        logic [SLOT_W-1:0] slot;
        logic hwy;
        logic sleep;
        logic cutoff;
        logic adc_gain;
        logic dac_gain;
        logic tone0;
        logic tone1;
    } set_s;

    set_s state;
    set_s next_state;

    always_comb begin
        next_state = state;
        if (bus.wr_en) begin
            unique case (bus.code)
                CMD_CODE_RX_SLOT: begin
                    next_state.slot = bus.wr_data[SLOT_W-1:0];
                    next_state.hwy = bus.wr_data[RX_HWY_BIT];
                end
                CMD_CODE_POWER: begin
                    // Low nibble is dropped; host must send zeros there
                    next_state.sleep = bus.wr_data[SLEEP_BIT];
                    next_state.cutoff = bus.wr_data[CUTOFF_BIT];
                    next_state.adc_gain = bus.wr_data[ADC_GAIN_BIT];
                    next_state.dac_gain = bus.wr_data[DAC_GAIN_BIT];
                end
                CMD_CODE_TONE: begin
                    next_state.tone1 = bus.wr_data[TONE1_BIT];
                    next_state.tone0 = bus.wr_data[TONE0_BIT];
                end
                default: begin
                    // Monitor registers are read only; writes ignored
                    next_state = state;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state.slot <= RX_SLOT_RESET;
            state.hwy <= RX_HWY_RESET;
            state.sleep <= SLEEP_RESET;
            state.cutoff <= CUTOFF_RESET;
            state.adc_gain <= ADC_GAIN_RESET;
            state.dac_gain <= DAC_GAIN_RESET;
            state.tone0 <= TONE_RESET;
            state.tone1 <= TONE_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign bus.rx_slot_number = state.slot;
    assign bus.rx_highway_select = state.hwy;
    assign bus.channel_sleep = state.sleep;
    assign bus.rx_path_cutoff = state.cutoff;
    assign bus.adc_gain_boost = state.adc_gain;
    assign bus.dac_gain_cut = state.dac_gain;
    assign bus.tone_gen_zero_on = state.tone0;
    assign bus.tone_gen_one_on = state.tone1;
endmodule

//--- codec_channel_local_regs.sv
`timescale 1ns/1ps
// Functional notes
// - Command bit 7 set means write, clear means read; receive slot is 05H read and 85H write.
// - Each channel holds a seven-bit receive slot 0..127, reset to zero.
// - Compressed coding uses the slot as one slot, linear coding as a slot group.
// - Bit 7 of the receive slot register picks the second receive highway when set, first when clear.
// - Command 06H reads the low byte of the transmit sample, or the whole byte when compressed.
// - Command 07H reads the high byte of the sample when linear and 00H when compressed.
// - Reading the monitors leaves the outgoing transmit sample untouched.
// - Bit 7 of register 08H powers the channel down when set and resets set.
// - Bit 6 cuts off the receive sample path when set and resets clear.
// - Bits 1 and 0 of register 09H enable tone generators one and zero and reset clear.
module codec_channel_local_regs #(
    parameter int NUM_CH = chan_regs_pkg::NUM_CHANNELS
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Management command port
    input wire logic i_cmd_valid,
    input wire logic [chan_regs_pkg::CMD_W-1:0] i_cmd,
    input wire logic [chan_regs_pkg::CHAN_W-1:0] i_chan,
    input wire logic [chan_regs_pkg::DATA_W-1:0] i_wr_data,
    output logic o_rd_valid,
    output logic [chan_regs_pkg::DATA_W-1:0] o_rd_data,
    output logic o_rd_hit,
    // Transmit sample path and coding mode
    input wire logic i_linear_mode,
    input wire logic [NUM_CH*chan_regs_pkg::SAMPLE_W-1:0] i_tx_sample,
    output logic [NUM_CH*chan_regs_pkg::SAMPLE_W-1:0] o_tx_sample,
    // Per-channel controls
    output logic [NUM_CH*chan_regs_pkg::SLOT_W-1:0] o_rx_slot_number,
    output logic [NUM_CH-1:0] o_rx_slot_group,
    output logic [NUM_CH-1:0] o_rx_highway_first,
    output logic [NUM_CH-1:0] o_rx_highway_second,
    output logic [NUM_CH-1:0] o_channel_sleep,
    output logic [NUM_CH-1:0] o_rx_path_cutoff,
    output logic [NUM_CH-1:0] o_adc_gain_boost,
    output logic [NUM_CH-1:0] o_dac_gain_cut,
    output logic [NUM_CH-1:0] o_tone_gen_zero_on,
    output logic [NUM_CH-1:0] o_tone_gen_one_on
);
    import chan_regs_pkg::*;

    if (NUM_CH < 1 || NUM_CH > (1 << CHAN_W)) begin : g_bad_ch
        $error("NUM_CH must fit the channel address");
    end

    typedef struct packed {
        logic rd_valid;
        logic rd_hit;
        logic [DATA_W-1:0] rd_data;
    } rd_s;

    rd_s state;
    rd_s next_state;

    logic is_write;
    logic [6:0] code;
    logic [DATA_W-1:0] slot_byte [NUM_CH];
    logic [DATA_W-1:0] power_byte [NUM_CH];
    logic [DATA_W-1:0] tone_byte [NUM_CH];

    assign is_write = i_cmd[CMD_RW_BIT];
    assign code = i_cmd[6:0];

    // Sample passes straight through; monitor reads only tap it
    assign o_tx_sample = i_tx_sample;

    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        chan_regs_if rif ();
        // Only the addressed channel takes the write
        assign rif.wr_en = i_cmd_valid && is_write && (i_chan == CHAN_W'(c));
        assign rif.wr_data = i_wr_data;
        assign rif.code = code;
        chan_reg_set u_set (
            .i_clk(i_clk),
            .i_rst(i_rst),
            .bus(rif.owner)
        );
        assign o_rx_slot_number[c*SLOT_W +: SLOT_W] = rif.rx_slot_number;
        assign o_rx_slot_group[c] = i_linear_mode;
        assign o_rx_highway_first[c] = ~rif.rx_highway_select;
        assign o_rx_highway_second[c] = rif.rx_highway_select;
        assign o_channel_sleep[c] = rif.channel_sleep;
        assign o_rx_path_cutoff[c] = rif.rx_path_cutoff;
        assign o_adc_gain_boost[c] = rif.adc_gain_boost;
        assign o_dac_gain_cut[c] = rif.dac_gain_cut;
        assign o_tone_gen_zero_on[c] = rif.tone_gen_zero_on;
        assign o_tone_gen_one_on[c] = rif.tone_gen_one_on;
        assign slot_byte[c] = {rif.rx_highway_select, rif.rx_slot_number};
        // Low nibble reads zero, as the host must write it
        assign power_byte[c] = {rif.channel_sleep, rif.rx_path_cutoff,
                                rif.adc_gain_boost, rif.dac_gain_cut, 4'h0};
        // Fixed ones read back in bits 3:2, reserved top nibble zero
        assign tone_byte[c] = {4'h0, TONE_FIXED_BITS[1:0], rif.tone_gen_one_on,
                               rif.tone_gen_zero_on};
    end

    always_comb begin
        logic [SAMPLE_W-1:0] smp;
        logic [CHAN_W-1:0] ch;
        smp = '0;
        ch = i_chan;
        next_state.rd_valid = i_cmd_valid && !is_write;
        next_state.rd_hit = 1'b0;
        next_state.rd_data = ZERO_BYTE;
        for (int k = 0; k < NUM_CH; k++) begin
            if (ch == CHAN_W'(k)) begin
                smp = i_tx_sample[k*SAMPLE_W +: SAMPLE_W];
            end
        end
        if (i_cmd_valid && !is_write && (int'(ch) < NUM_CH)) begin
            next_state.rd_hit = 1'b1;
            unique case (code)
                CMD_CODE_RX_SLOT: next_state.rd_data = slot_byte[ch];
                CMD_CODE_MON_LOW: next_state.rd_data = smp[DATA_W-1:0];
                CMD_CODE_MON_HIGH: begin
                    next_state.rd_data = i_linear_mode ? smp[SAMPLE_W-1:DATA_W]
                                                       : ZERO_BYTE;
                end
                CMD_CODE_POWER: next_state.rd_data = power_byte[ch];
                CMD_CODE_TONE: next_state.rd_data = tone_byte[ch];
                default: next_state.rd_hit = 1'b0;
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_rd_valid = state.rd_valid;
    assign o_rd_hit = state.rd_hit;
    assign o_rd_data = state.rd_data;
endmodule

//--- regs_chk_sva.sv
`timescale 1ns/1ps
module regs_chk #(
    parameter int NUM_CH = 4
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_cmd_valid,
    input wire logic [7:0] i_cmd,
    input wire logic [1:0] i_chan,
    input wire logic [7:0] i_wr_data,
    input wire logic o_rd_valid,
    input wire logic [7:0] o_rd_data,
    input wire logic i_linear_mode,
    input wire logic [NUM_CH*16-1:0] i_tx_sample,
    input wire logic [NUM_CH*16-1:0] o_tx_sample,
    input wire logic [NUM_CH*7-1:0] o_rx_slot_number,
    input wire logic [NUM_CH-1:0] o_rx_slot_group,
    input wire logic [NUM_CH-1:0] o_rx_highway_second,
    input wire logic [NUM_CH-1:0] o_channel_sleep,
    input wire logic [NUM_CH-1:0] o_tone_gen_one_on
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire rd = i_cmd_valid && !i_cmd[7];
    wire [7:0] low_now = i_tx_sample[i_chan*16 +: 8];
    wire [7:0] high_now = i_tx_sample[i_chan*16+8 +: 8];
    read_answer_a: assert property (rd |=> o_rd_valid) else $error("read unanswered");
    idle_data_a: assert property (!rd |=> !o_rd_valid && o_rd_data == 8'h00)
        else $error("idle read data");
    slot_write_a: assert property (i_cmd_valid && i_cmd == 8'h85 |=>
        o_rx_slot_number[$past(i_chan)*7 +: 7] == $past(i_wr_data[6:0])) else $error("slot");
    highway_write_a: assert property (i_cmd_valid && i_cmd == 8'h85 |=>
        o_rx_highway_second[$past(i_chan)] == $past(i_wr_data[7])) else $error("highway");
    slot_group_a: assert property (o_rx_slot_group == {NUM_CH{i_linear_mode}})
        else $error("slot group");
    mon_low_a: assert property (rd && i_cmd == 8'h06 |=>
        o_rd_data == $past(low_now)) else $error("low byte");
    mon_high_a: assert property (rd && i_cmd == 8'h07 |=> o_rd_data ==
        ($past(i_linear_mode) ? $past(high_now) : 8'h00)) else $error("high");
    tx_pass_a: assert property (o_tx_sample == i_tx_sample) else $error("tx sample");
    sleep_write_a: assert property (i_cmd_valid && i_cmd == 8'h88 |=>
        o_channel_sleep[$past(i_chan)] == $past(i_wr_data[7])) else $error("sleep");
    tone_write_a: assert property (i_cmd_valid && i_cmd == 8'h89 |=>
        o_tone_gen_one_on[$past(i_chan)] == $past(i_wr_data[1])) else $error("tone");
endmodule

//--- mcu_host.sv
`timescale 1ns/1ps
module mcu_host (
    // Answer
    input wire logic i_clk,
    input wire logic i_rd_valid,
    input wire logic [7:0] i_rd_data,
    input wire logic i_rd_hit,
    // Command port
    output logic o_cmd_valid,
    output logic [7:0] o_cmd,
    output logic [1:0] o_chan,
    output logic [7:0] o_wr_data
);
    logic [9:0] got;
    initial o_cmd_valid = 1'b0;
    task automatic access(input logic [7:0] cmd, input logic [1:0] ch, input logic [7:0] d);
        logic [7:0] wd;
        wd = d;
        if (cmd == 8'h88) wd[3:0] = 4'h0;
        if (cmd == 8'h89) wd[3:2] = 2'h3;
        @(negedge i_clk);
        o_cmd_valid = 1'b1;
        o_cmd = cmd;
        o_chan = ch;
        o_wr_data = wd;
        // Answer stands only for the cycle after the taking edge
        @(negedge i_clk);
        got = {i_rd_valid, i_rd_hit, i_rd_data};
        o_cmd_valid = 1'b0;
        // Released lines flip so a stale value never looks live
        o_cmd = ~cmd;
        o_chan = ~ch;
        o_wr_data = ~wd;
    endtask
endmodule

//--- codec_channel_local_regs_bench.sv
`timescale 1ns/1ps
module codec_channel_local_regs_bench;
    logic i_clk, i_rst, vld, hit, rv, lin;
    logic [7:0] cmd, wd, rdat;
    logic [1:0] ch;
    logic [63:0] tx = 64'h8001_7f7e_00ff_a55a;
    logic [63:0] txo;
    logic [27:0] slot;
    logic [3:0] grp, hw1, hw2, slp, cut, adc, dac, t0, t1;
    logic [7:0] s_tab [4] = '{8'h7f, 8'h81, 8'h80, 8'h3c};
    logic [7:0] c_tab [4] = '{8'h0f, 8'hc0, 8'h20, 8'h90};
    logic [7:0] t_tab [4] = '{8'h03, 8'h01, 8'h02, 8'h00};
    int n_mismatch = 0;
    int total_checks = 0;
    codec_channel_local_regs codec_channel_local_regs_i (.i_clk(i_clk), .i_rst(i_rst),
        .i_cmd_valid(vld), .i_cmd(cmd), .i_chan(ch), .i_wr_data(wd), .o_rd_valid(rv),
        .o_rd_data(rdat), .o_rd_hit(hit), .i_linear_mode(lin), .i_tx_sample(tx),
        .o_tx_sample(txo), .o_rx_slot_number(slot), .o_rx_slot_group(grp),
        .o_rx_highway_first(hw1), .o_rx_highway_second(hw2), .o_channel_sleep(slp),
        .o_rx_path_cutoff(cut), .o_adc_gain_boost(adc), .o_dac_gain_cut(dac),
        .o_tone_gen_zero_on(t0), .o_tone_gen_one_on(t1));
    mcu_host mcu_host_i (.i_clk(i_clk), .i_rd_valid(rv), .i_rd_data(rdat), .i_rd_hit(hit),
        .o_cmd_valid(vld), .o_cmd(cmd), .o_chan(ch), .o_wr_data(wd));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic chk(input string name, input logic [63:0] exp_v, input logic [63:0] got);
        total_checks++;
        if (got !== exp_v) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp_v, got);
        end
    endtask
    task automatic rd(input logic [7:0] c, input int n, input logic [7:0] e, input logic h);
        mcu_host_i.access(c, n[1:0], 8'h00);
        chk("read", {54'h0, 1'b1, h, e}, {54'h0, mcu_host_i.got});
    endtask
    task automatic check_reset();
        for (int c = 0; c < 4; c++) begin
            rd(8'h05, c, 8'h00, 1'b1);
            rd(8'h08, c, 8'h80, 1'b1);
            rd(8'h09, c, 8'h0c, 1'b1);
        end
        chk("resets", 64'hf00000f0, {4'h0, slot, slp, cut, adc, dac, t0, t1, hw1, hw2});
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        i_rst = 1'b1;
        lin = 1'b0;
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        i_rst = 1'b0;
        check_reset();
        for (int c = 0; c < 4; c++) begin
            mcu_host_i.access(8'h85, c[1:0], s_tab[c]);
            mcu_host_i.access(8'h88, c[1:0], c_tab[c]);
            mcu_host_i.access(8'h89, c[1:0], t_tab[c]);
        end
        mcu_host_i.access(8'h86, 2'h0, 8'h77);
        for (int c = 0; c < 4; c++) begin
            rd(8'h05, c, s_tab[c], 1'b1);
            rd(8'h08, c, c_tab[c] & 8'hf0, 1'b1);
            rd(8'h09, c, t_tab[c] | 8'h0c, 1'b1);
            chk("slot", {56'h0, s_tab[c]}, {56'h0, hw2[c], slot[c*7 +: 7]});
            chk("first", {63'h0, ~s_tab[c][7]}, {63'h0, hw1[c]});
            chk("sleep cut", {62'h0, c_tab[c][7:6]}, {62'h0, slp[c], cut[c]});
            chk("adc", {63'h0, c_tab[c][5]}, {63'h0, adc[c]});
            chk("dac", {63'h0, c_tab[c][4]}, {63'h0, dac[c]});
            chk("tone", {62'h0, t_tab[c][1:0]}, {62'h0, t1[c], t0[c]});
        end
        for (int m = 0; m < 2; m++) begin
            lin = m[0];
            // Let the mode settle before looking at the group flags
            @(posedge i_clk);
            chk("group", {60'h0, {4{lin}}}, {60'h0, grp});
            for (int c = 0; c < 4; c++) begin
                rd(8'h06, c, tx[c*16 +: 8], 1'b1);
                rd(8'h07, c, lin ? tx[c*16+8 +: 8] : 8'h00, 1'b1);
                chk("tx", tx, txo);
            end
        end
        // Mid-run reset must bring every channel copy back to defaults
        @(negedge i_clk);
        i_rst = 1'b1;
        @(negedge i_clk);
        i_rst = 1'b0;
        check_reset();
        rd(8'h0a, 0, 8'h00, 1'b0);
        finish_test();
    end
    // About 70 accesses of 2 cycles; the limit leaves a wide margin
    initial begin
        #20000;
        n_mismatch++;
        finish_test();
    end
endmodule
bind codec_channel_local_regs regs_chk #(.NUM_CH(NUM_CH)) regs_chk_i (.i_clk(i_clk),
    .i_rst(i_rst), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_chan(i_chan),
    .i_wr_data(i_wr_data), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
    .i_linear_mode(i_linear_mode), .i_tx_sample(i_tx_sample), .o_tx_sample(o_tx_sample),
    .o_rx_slot_number(o_rx_slot_number), .o_rx_slot_group(o_rx_slot_group),
    .o_rx_highway_second(o_rx_highway_second), .o_channel_sleep(o_channel_sleep),
    .o_tone_gen_one_on(o_tone_gen_one_on));
